/* core/ckg_cfg_regs.sv */
`timescale 1ns/10ps
`include "ckg_regs.svh"

module ckg_cfg_regs
#(
    parameter logic [7:0] VARIANT_ID = 8'h5A  // arbitrary value
)
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // register access from the serial control port engine
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        io_update,
    // stored-config select pin
    input  wire logic        stored_cfg_sel,
    // stored image read port
    output logic             nvm_rd,
    output logic [1:0]       nvm_addr,
    input  wire logic [7:0]  nvm_rdata,
    output logic             soft_reset_busy,
    // loop settings from the active bank
    output logic             phase_detector_polarity,
    output logic [2:0]       pump_current_setting,
    output logic [5:0]       pump_current_ma_x10,
    output ckg_pkg::ckg_pump_mode_t pump_operating_mode,
    output logic             pump_hiz,
    output logic             pump_force_source,
    output logic             pump_force_sink
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // readback picks the active or staged copy
    function automatic logic [7:0] pick_bank(input logic sel, input logic [7:0] stg, input logic [7:0] act);
        pick_bank = sel ? act : stg;
    endfunction

    // pump current in tenths of a milliamp for a 3-bit code
    function automatic logic [5:0] pump_x10(input logic [2:0] code);
        pump_x10 = `CKG_PUMP_STEP_X10 * ({3'h0, code} + 6'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic       sel_meta_r;
    logic       sel_r;
    logic [7:0] bank_sel_r;
    logic [7:0] tag_lo_stg_r;
    logic [7:0] tag_hi_stg_r;
    logic [7:0] loop_stg_r;
    logic [7:0] tag_lo_act_r;
    logic [7:0] tag_hi_act_r;
    logic [7:0] loop_act_r;
    logic       ld_start;
    logic       ld_busy;
    logic       ld_we;
    logic [1:0] ld_idx;
    logic [7:0] ld_data;
    logic       wr_ok;
    logic       wr_pcfg;
    logic       soft_req;
    logic       soft_dflt;
    logic       wr_bsel;
    logic       wr_tag_lo;
    logic       wr_tag_hi;
    logic       wr_loop;
    logic       ld_bsel;
    logic       ld_tag_lo;
    logic       ld_tag_hi;
    logic       ld_loop;
    logic       bank_active;
    logic [7:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////////
    // select pin synchroniser

    // two flops before anything looks at the pin
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_meta_r <= 1'b0;
            sel_r      <= 1'b0;
        end
        else
        begin
            sel_meta_r <= stored_cfg_sel;
            sel_r      <= sel_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write decode

    // writes are refused while an image load runs, its last word included
    assign wr_ok     = reg_wr && !soft_reset_busy;
    assign wr_pcfg   = wr_ok && (reg_addr == `CKG_ADDR_PORT_CFG);
    assign soft_req  = wr_pcfg && reg_wdata[`CKG_PCFG_SOFT_RESET];
    assign soft_dflt = soft_req && !sel_r;
    assign ld_start  = soft_req && sel_r;
    assign wr_bsel   = wr_ok && (reg_addr == `CKG_ADDR_BANK_SEL);
    assign wr_tag_lo = wr_ok && (reg_addr == `CKG_ADDR_TAG_LO);
    assign wr_tag_hi = wr_ok && (reg_addr == `CKG_ADDR_TAG_HI);
    assign wr_loop   = wr_ok && (reg_addr == `CKG_ADDR_LOOP_CTRL);
    assign ld_bsel   = ld_we && (ld_idx == `CKG_NVM_IDX_BSEL);
    assign ld_tag_lo = ld_we && (ld_idx == `CKG_NVM_IDX_TAG_LO);
    assign ld_tag_hi = ld_we && (ld_idx == `CKG_NVM_IDX_TAG_HI);
    assign ld_loop   = ld_we && (ld_idx == `CKG_NVM_IDX_LOOP);

    ////////////////////////////////////////////////////////////////////////////////
    // stored image loader

    ckg_nvm_loader u_loader
    (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .start     (ld_start),
        .busy      (ld_busy),
        .nvm_rd    (nvm_rd),
        .nvm_addr  (nvm_addr),
        .nvm_rdata (nvm_rdata),
        .ld_we     (ld_we),
        .ld_idx    (ld_idx),
        .ld_data   (ld_data)
    );

    // the last image word lands one cycle after the loader goes idle
    assign soft_reset_busy = ld_busy || ld_we;

    ////////////////////////////////////////////////////////////////////////////////
    // readback bank select, not staged

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            bank_sel_r <= `CKG_RST_BANK_SEL;
        else if (soft_dflt)
            bank_sel_r <= `CKG_RST_BANK_SEL;
        else if (ld_bsel)
            bank_sel_r <= ld_data & `CKG_BSEL_MASK;
        else if (wr_bsel)
            bank_sel_r <= reg_wdata & `CKG_BSEL_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // staged copies, written by the host

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tag_lo_stg_r <= `CKG_RST_TAG;
            tag_hi_stg_r <= `CKG_RST_TAG;
            loop_stg_r   <= `CKG_RST_LOOP_CTRL;
        end
        else if (soft_dflt)
        begin
            tag_lo_stg_r <= `CKG_RST_TAG;
            tag_hi_stg_r <= `CKG_RST_TAG;
            loop_stg_r   <= `CKG_RST_LOOP_CTRL;
        end
        else
        begin
            if (ld_tag_lo || wr_tag_lo)
                tag_lo_stg_r <= ld_tag_lo ? ld_data : reg_wdata;
            if (ld_tag_hi || wr_tag_hi)
                tag_hi_stg_r <= ld_tag_hi ? ld_data : reg_wdata;
            if (ld_loop || wr_loop)
                loop_stg_r   <= (ld_loop ? ld_data : reg_wdata) & `CKG_LOOP_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // active copies, taken on io_update or reset load

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tag_lo_act_r <= `CKG_RST_TAG;
            tag_hi_act_r <= `CKG_RST_TAG;
            loop_act_r   <= `CKG_RST_LOOP_CTRL;
        end
        else if (soft_dflt)
        begin
            tag_lo_act_r <= `CKG_RST_TAG;
            tag_hi_act_r <= `CKG_RST_TAG;
            loop_act_r   <= `CKG_RST_LOOP_CTRL;
        end
        else if (ld_we)
        begin
            // image words go live at once
            if (ld_tag_lo)
                tag_lo_act_r <= ld_data;
            if (ld_tag_hi)
                tag_hi_act_r <= ld_data;
            if (ld_loop)
                loop_act_r   <= ld_data & `CKG_LOOP_MASK;
        end
        else if (io_update && !soft_reset_busy)
        begin
            tag_lo_act_r <= tag_lo_stg_r;
            tag_hi_act_r <= tag_hi_stg_r;
            loop_act_r   <= loop_stg_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // readback

    assign bank_active = bank_sel_r[`CKG_BSEL_ACTIVE];

    // port config reads zero: soft reset clears itself, other bits unused
    always_comb
    begin
        case (reg_addr)
            `CKG_ADDR_PORT_CFG:   rd_mux = 8'h00;
            `CKG_ADDR_VARIANT_ID: rd_mux = VARIANT_ID;
            `CKG_ADDR_BANK_SEL:   rd_mux = bank_sel_r;
            `CKG_ADDR_TAG_LO:     rd_mux = pick_bank(bank_active, tag_lo_stg_r, tag_lo_act_r);
            `CKG_ADDR_TAG_HI:     rd_mux = pick_bank(bank_active, tag_hi_stg_r, tag_hi_act_r);
            `CKG_ADDR_LOOP_CTRL:  rd_mux = pick_bank(bank_active, loop_stg_r, loop_act_r);
            default:              rd_mux = 8'h00;
        endcase
    end

    // read data one cycle after the request
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // loop settings

    assign phase_detector_polarity = loop_act_r[`CKG_LOOP_POL];
    assign pump_current_setting    = loop_act_r[`CKG_LOOP_CUR_HI:`CKG_LOOP_CUR_LO];
    assign pump_current_ma_x10     = pump_x10(pump_current_setting);
    assign pump_operating_mode     = ckg_pkg::ckg_pump_mode_t'(loop_act_r[`CKG_LOOP_MODE_HI:`CKG_LOOP_MODE_LO]);
    assign pump_hiz                = (pump_operating_mode == ckg_pkg::CKG_PUMP_HIZ);
    assign pump_force_source       = (pump_operating_mode == ckg_pkg::CKG_PUMP_SOURCE);
    assign pump_force_sink         = (pump_operating_mode == ckg_pkg::CKG_PUMP_SINK);

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_soft_write(logic pin);
        wr_pcfg && reg_wdata[`CKG_PCFG_SOFT_RESET] && (sel_r == pin);
    endsequence

    sequence s_read_at(logic [11:0] a);
        reg_rd && (reg_addr == a);
    endsequence

    property p_soft_nvm;
        @(posedge mclk) disable iff (!reset_n)
        s_soft_write(1'b1) |=> ld_busy ##[1:8] ld_we;
    endproperty
    a_soft_nvm: assert property (p_soft_nvm) else $error("soft reset did not load image");

    property p_soft_default;
        @(posedge mclk) disable iff (!reset_n)
        s_soft_write(1'b0) |=> (loop_act_r == `CKG_RST_LOOP_CTRL) && (tag_lo_act_r == 8'h00)
                               && (bank_sel_r == 8'h00) && !ld_busy;
    endproperty
    a_soft_default: assert property (p_soft_default) else $error("soft reset defaults wrong");

    property p_self_clear;
        @(posedge mclk) disable iff (!reset_n)
        s_read_at(`CKG_ADDR_PORT_CFG) |=> reg_rvalid && (reg_rdata == 8'h00);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("port config not zero");

    property p_variant;
        @(posedge mclk) disable iff (!reset_n)
        s_read_at(`CKG_ADDR_VARIANT_ID) |=> (reg_rdata == VARIANT_ID);
    endproperty
    a_variant: assert property (p_variant) else $error("variant identifier wrong");

    property p_bank;
        @(posedge mclk) disable iff (!reset_n)
        s_read_at(`CKG_ADDR_LOOP_CTRL) |=>
            (reg_rdata == ($past(bank_active) ? $past(loop_act_r) : $past(loop_stg_r)));
    endproperty
    a_bank: assert property (p_bank) else $error("readback bank wrong");

    property p_tag_store;
        @(posedge mclk) disable iff (!reset_n)
        (wr_tag_hi && !ld_we && !soft_dflt) |=> (tag_hi_stg_r == $past(reg_wdata));
    endproperty
    a_tag_store: assert property (p_tag_store) else $error("tag write lost");

    property p_polarity;
        @(posedge mclk) disable iff (!reset_n)
        (io_update && !ld_busy && !ld_we && !soft_dflt) |=> (phase_detector_polarity == $past(loop_stg_r[7]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity not applied");

    property p_current;
        @(posedge mclk) disable iff (!reset_n)
        pump_current_ma_x10 == 6'(6 * (pump_current_setting + 3'h1)) && pump_current_ma_x10 != 6'h00;
    endproperty
    a_current: assert property (p_current) else $error("pump current step wrong");

    property p_mode;
        @(posedge mclk) disable iff (!reset_n)
        ($countones({pump_hiz, pump_force_source, pump_force_sink}) <= 1)
        && ((loop_act_r[3:2] == 2'h3) == !(pump_hiz || pump_force_source || pump_force_sink));
    endproperty
    a_mode: assert property (p_mode) else $error("pump mode decode wrong");

    property p_unused;
        @(posedge mclk) disable iff (!reset_n)
        s_read_at(`CKG_ADDR_BANK_SEL) or s_read_at(`CKG_ADDR_LOOP_CTRL) |=> (reg_rdata[1:0] == 2'h0
            || $past(reg_addr) == `CKG_ADDR_BANK_SEL) && ($past(reg_addr) != `CKG_ADDR_BANK_SEL || reg_rdata[7:1] == 7'h00);
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits not zero");

endmodule

/* core/ckg_regs.svh */
`ifndef CKG_REGS_SVH
`define CKG_REGS_SVH

// register offsets on the serial control port
`define CKG_ADDR_PORT_CFG     12'h000
`define CKG_ADDR_VARIANT_ID   12'h003
`define CKG_ADDR_BANK_SEL     12'h004
`define CKG_ADDR_TAG_LO       12'h005
`define CKG_ADDR_TAG_HI       12'h006
`define CKG_ADDR_LOOP_CTRL    12'h010

// field positions
`define CKG_PCFG_SOFT_RESET   5
`define CKG_BSEL_ACTIVE       0
`define CKG_LOOP_POL          7
`define CKG_LOOP_CUR_HI       6
`define CKG_LOOP_CUR_LO       4
`define CKG_LOOP_MODE_HI      3
`define CKG_LOOP_MODE_LO      2

// writable bit masks, everything else reads as zero
`define CKG_BSEL_MASK         8'h01
`define CKG_LOOP_MASK         8'hFC

// reset values
`define CKG_RST_BANK_SEL      8'h00
`define CKG_RST_TAG           8'h00
`define CKG_RST_LOOP_CTRL     8'h7C

// stored image layout: word index of each register
`define CKG_NVM_WORDS         3'h4
`define CKG_NVM_IDX_BSEL      2'h0
`define CKG_NVM_IDX_TAG_LO    2'h1
`define CKG_NVM_IDX_TAG_HI    2'h2
`define CKG_NVM_IDX_LOOP      2'h3

// one pump current step, in tenths of a milliamp
`define CKG_PUMP_STEP_X10     6'h06

`endif

/* core/ckg_pkg.sv */
package ckg_pkg;

    // pump output behaviour, encoded as the field
    typedef enum logic [1:0] {
        CKG_PUMP_HIZ    = 2'h0,
        CKG_PUMP_SOURCE = 2'h1,
        CKG_PUMP_SINK   = 2'h2,
        CKG_PUMP_NORMAL = 2'h3
    } ckg_pump_mode_t;

    // stored-image loader sequence
    typedef enum logic [1:0] {
        CKG_LD_IDLE,
        CKG_LD_FETCH,
        CKG_LD_CAPTURE
    } ckg_ld_state_t;

endpackage

/* core/ckg_nvm_loader.sv */
`timescale 1ns/10ps
`include "ckg_regs.svh"

module ckg_nvm_loader
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // control
    input  wire logic       start,
    output logic            busy,
    // stored image read port, data one cycle after nvm_rd
    output logic            nvm_rd,
    output logic [1:0]      nvm_addr,
    input  wire logic [7:0] nvm_rdata,
    // loaded word towards the register bank
    output logic            ld_we,
    output logic [1:0]      ld_idx,
    output logic [7:0]      ld_data
);

    ckg_pkg::ckg_ld_state_t state_r;
    ckg_pkg::ckg_ld_state_t state_nxt;
    logic [1:0]             idx_r;
    logic                   last_word;

    assign last_word = (idx_r == 2'(`CKG_NVM_WORDS - 3'h1));
    assign busy      = (state_r != ckg_pkg::CKG_LD_IDLE);
    assign nvm_rd    = (state_r == ckg_pkg::CKG_LD_FETCH);
    assign nvm_addr  = idx_r;

    // walk the image one word per fetch and capture pair
    always_comb
    begin
        case (state_r)
            ckg_pkg::CKG_LD_IDLE:    state_nxt = start ? ckg_pkg::CKG_LD_FETCH : ckg_pkg::CKG_LD_IDLE;
            ckg_pkg::CKG_LD_FETCH:   state_nxt = ckg_pkg::CKG_LD_CAPTURE;
            ckg_pkg::CKG_LD_CAPTURE: state_nxt = last_word ? ckg_pkg::CKG_LD_IDLE : ckg_pkg::CKG_LD_FETCH;
            default:                 state_nxt = ckg_pkg::CKG_LD_IDLE;
        endcase
    end

    // state, word index and captured data
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ckg_pkg::CKG_LD_IDLE;
            idx_r   <= 2'h0;
            ld_we   <= 1'b0;
            ld_idx  <= 2'h0;
            ld_data <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            ld_we   <= (state_r == ckg_pkg::CKG_LD_CAPTURE);
            ld_idx  <= idx_r;
            if (state_r == ckg_pkg::CKG_LD_CAPTURE)
            begin
                ld_data <= nvm_rdata;
                idx_r   <= idx_r + 2'h1;
            end
            else if (state_r == ckg_pkg::CKG_LD_IDLE)
                idx_r <= 2'h0;
        end
    end

    // a load lasts exactly four fetch and capture pairs
    property p_load_length;
        @(posedge mclk) disable iff (!reset_n)
        (start && !busy) |=> busy [*8] ##1 !busy;
    endproperty
    a_load_length: assert property (p_load_length) else $error("image load length wrong");

endmodule

/* verification/ckg_nvm_model.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// stored image behind the loader read port
module ckg_nvm_model
(
    // clock
    input  wire logic       mclk,
    // read port
    input  wire logic       nvm_rd,
    input  wire logic [1:0] nvm_addr,
    output logic [7:0]      nvm_rdata
);
    // image words: bank select, tag low, tag high, loop control
    logic [7:0] image [4];

    initial
    begin
        image[0]  = 8'hFF;
        image[1]  = 8'h3C;
        image[2]  = 8'hC3;
        image[3]  = 8'hA7;
        nvm_rdata = 8'h00;
    end

    // word valid in the cycle after the request, otherwise a changing pattern
    always @(posedge mclk)
    begin
        if (nvm_rd === 1'b1)
            nvm_rdata <= image[nvm_addr];
        else
            nvm_rdata <= ~nvm_rdata;
    end
endmodule

/* verification/ckg_cfg_regs_tb.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// bench for the configuration register bank
module ckg_cfg_regs_tb;
    localparam logic [7:0] VID = 8'hC5; // arbitrary value

    logic                    mclk;
    logic                    reset_n;
    logic [11:0]             reg_addr;
    logic                    reg_wr;
    logic [7:0]              reg_wdata;
    logic                    reg_rd;
    logic [7:0]              reg_rdata;
    logic                    reg_rvalid;
    logic                    io_update;
    logic                    stored_cfg_sel;
    logic                    nvm_rd;
    logic [1:0]              nvm_addr;
    logic [7:0]              nvm_rdata;
    logic                    soft_reset_busy;
    logic                    phase_detector_polarity;
    logic [2:0]              pump_current_setting;
    logic [5:0]              pump_current_ma_x10;
    ckg_pkg::ckg_pump_mode_t pump_operating_mode;
    logic                    pump_hiz;
    logic                    pump_force_source;
    logic                    pump_force_sink;
    logic [7:0]              exp_q [$];
    int                      failures;
    int                      tests_run;

    ckg_cfg_regs #(.VARIANT_ID(VID)) ckg_cfg_regs_inst
    (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .io_update(io_update),
        .stored_cfg_sel(stored_cfg_sel), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
        .soft_reset_busy(soft_reset_busy), .phase_detector_polarity(phase_detector_polarity),
        .pump_current_setting(pump_current_setting), .pump_current_ma_x10(pump_current_ma_x10),
        .pump_operating_mode(pump_operating_mode), .pump_hiz(pump_hiz),
        .pump_force_source(pump_force_source), .pump_force_sink(pump_force_sink)
    );

    ckg_nvm_model ckg_nvm_model_inst
    (
        .mclk(mclk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial
    begin
        #(50 * 4000);
        failures++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge mclk);
        #2;
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_rd   = 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        #2;
        reg_rd = 1'b0;
    endtask

    task automatic upd();
        @(posedge mclk);
        #2;
        io_update = 1'b1;
        @(posedge mclk);
        #2;
        io_update = 1'b0;
    endtask

    // loop outputs against the active loop control byte v
    task automatic chk_out(input logic [7:0] v);
        chk({7'h0, phase_detector_polarity}, {7'h0, v[7]}, "polarity");
        chk({5'h0, pump_current_setting}, {5'h0, v[6:4]}, "current code");
        chk({2'h0, pump_current_ma_x10}, ({5'h0, v[6:4]} + 8'h01) * 8'h06, "current ma");
        chk({6'h0, pump_operating_mode}, {6'h0, v[3:2]}, "mode");
        chk({5'h0, pump_hiz, pump_force_source, pump_force_sink},
            {5'h0, v[3:2] == 2'h0, v[3:2] == 2'h1, v[3:2] == 2'h2}, "mode decode");
    endtask

    task automatic note(input string n);
        $display("test %s done: %0d checks, %0d failures", n, tests_run, failures);
    endtask

    task automatic complete_run();
        $display("checks %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // read monitor: oldest expectation against each returned byte
    always @(negedge mclk)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                failures++;
                $display("[FAIL] %0t read data with nothing expected", $time);
            end
            else
                chk(reg_rdata, exp_q.pop_front(), "read data");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [31:0] t;
        logic [7:0]  v;
        int          n;
        reset_n        = 1'b0;
        reg_addr       = 12'h000;
        reg_wr         = 1'b0;
        reg_wdata      = 8'h00;
        reg_rd         = 1'b0;
        io_update      = 1'b0;
        stored_cfg_sel = 1'b0;
        failures       = 0;
        tests_run      = 0;
        void'($urandom(26124));
        repeat (10) @(posedge mclk);
        #2;
        reset_n = 1'b1;
        // reset values
        chk_out(8'h7C);
        rd(12'h000, 8'h00);
        rd(12'h003, VID);
        rd(12'h004, 8'h00);
        rd(12'h005, 8'h00);
        rd(12'h006, 8'h00);
        rd(12'h010, 8'h7C);
        rd(12'h7FF, 8'h00);
        note("reset");
        // storage, read-only and unused bits
        t = $urandom;
        wr(12'h005, t[7:0]);
        wr(12'h006, t[15:8]);
        wr(12'h003, ~VID);
        wr(12'h004, 8'hFE);
        wr(12'h7FF, 8'hFF);
        wr(12'h000, 8'hDB);
        chk({7'h0, soft_reset_busy}, 8'h00, "no reset without bit 5");
        rd(12'h005, t[7:0]);
        rd(12'h006, t[15:8]);
        rd(12'h003, VID);
        rd(12'h004, 8'h00);
        rd(12'h000, 8'h00);
        chk_out(8'h7C);
        note("storage");
        // staged against active readback
        v = t[23:16];
        wr(12'h010, v);
        chk_out(8'h7C);
        rd(12'h010, v & 8'hFC);
        wr(12'h004, 8'h01);
        rd(12'h004, 8'h01);
        rd(12'h010, 8'h7C);
        upd();
        chk_out(v);
        rd(12'h010, v & 8'hFC);
        wr(12'h004, 8'h00);
        note("bank");
        // every current code and pump mode
        for (int i = 0; i < 32; i++)
        begin
            t = $urandom;
            v = {1'b0, i[4:2], i[1:0], t[2:1]};
            wr(12'h010, v);
            upd();
            chk_out(v);
            rd(12'h010, v & 8'hFC);
        end
        note("codes");
        // soft reset with select pin low
        wr(12'h004, 8'h01);
        wr(12'h000, 8'h24);
        chk({7'h0, soft_reset_busy}, 8'h00, "default load busy");
        chk_out(8'h7C);
        rd(12'h004, 8'h00);
        rd(12'h005, 8'h00);
        rd(12'h006, 8'h00);
        rd(12'h010, 8'h7C);
        note("defaults");
        // soft reset with select pin high
        stored_cfg_sel = 1'b1;
        repeat (3) @(posedge mclk);
        wr(12'h000, 8'h24);
        n = 0;
        while (soft_reset_busy === 1'b1 && n < 20)
        begin
            @(posedge mclk);
            #2;
            n++;
        end
        chk(n[7:0], 8'h09, "image load length");
        chk_out(8'hA4);
        rd(12'h004, 8'h01);
        rd(12'h005, 8'h3C);
        rd(12'h006, 8'hC3);
        rd(12'h010, 8'hA4);
        note("image");
        repeat (3) @(posedge mclk);
        if (exp_q.size() != 0)
        begin
            failures++;
            $display("[FAIL] %0t reads left unanswered", $time);
        end
        complete_run();
    end
endmodule
